// ### design/pfg_pkg.sv
// Package for the packet FEC frame generator: frame geometry, FEC header
// fields, field arithmetic and the code generator polynomial.
// Assumes a byte stream from a packet multiplexer, one clock domain.
package pfg_pkg;

   // ------------------------------------------------------------------
   // Frame geometry
   // ------------------------------------------------------------------
   localparam int ROWS        = 12;
   localparam int DATA_COLS   = 188;
   localparam int PAR_COLS    = 16;
   localparam int SHORT_ZEROS = 51;
   localparam int FEC_PKTS    = 9;
   localparam int FEC_PKT_LEN = 24;
   localparam int FEC_HDR_LEN = 2;
   localparam int FIFO_DEPTH  = 16;

   // ------------------------------------------------------------------
   // FEC packet header fields
   // ------------------------------------------------------------------
   localparam logic [1:0] FEC_LEN_CODE = 2'h0;
   localparam logic [9:0] FEC_ADDR     = 10'h3fe;

   // ------------------------------------------------------------------
   // Field arithmetic
   // ------------------------------------------------------------------
   localparam logic [7:0] FIELD_POLY = 8'h1d;
   localparam logic [7:0] ALPHA      = 8'h02;

   typedef enum logic [1:0] {PFG_DATA = 2'h0, PFG_FEC = 2'h1} pfg_state_t;

   function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] aa;
      p  = 8'h00;
      aa = a;
      for (int i = 0; i < 8; i++)
      begin
         if (b[i])
            p = p ^ aa;
         aa = aa[7] ? ({aa[6:0], 1'b0} ^ FIELD_POLY) : {aa[6:0], 1'b0};
      end
      return p;
   endfunction

   // Coefficients g0..g16 of the product of (x + alpha^i), i = 0..15
   function automatic logic [135:0] gen_poly();
      logic [135:0] g;
      logic [7:0]   a;
      g = 136'h1;
      a = 8'h01;
      for (int i = 0; i < PAR_COLS; i++)
      begin
         for (int j = PAR_COLS; j > 0; j--)
            g[8*j +: 8] = g[8*(j-1) +: 8] ^ gf_mul(a, g[8*j +: 8]);
         g[7:0] = gf_mul(a, g[7:0]);
         a = gf_mul(a, ALPHA);
      end
      return g;
   endfunction

endpackage

// ### design/pfg_frame_gen.sv
// Packet FEC frame generator: forwards a set of packets, accumulates
// row parity of a 12 x 188 table, then emits nine 24-byte FEC packets.
// Assumes upstream delivers exactly one table of bytes per set.
//
// Summary of operation
// - Forward packets unchanged, then nine FEC packets
// - Next set starts right after ninth FEC
// - Parity covers every byte, any address
// - Frame is 12 rows, 188 data, 16 parity
// - Bytes fill table down rows, then columns
// - Rows coded RS(204,188), roots alpha^0..15
// - Leading shortening zeros leave encoder state zero
// - First parity byte goes to parity column 1
// - 192 parity bytes in nine following packets
// - FEC header: length code 00, 22 parity bytes
// - FEC counter runs 0 to 8
// - FEC address is 1111111110
// - Header bits match ordinary packet header positions
// - Parity sent down rows, then columns
// - Last six bytes of ninth packet zero

`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Byte FIFO
// ----------------------------------------------------------------------
module pfg_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // Fill side
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic             wr_valid,
   output logic                  wr_ready,
   // Drain side
   output logic      [WIDTH-1:0] rd_data,
   output logic                  rd_valid,
   input  wire logic             rd_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign push     = wr_valid && wr_ready;
   assign pop      = rd_valid && rd_ready;
   assign rd_valid = (count != '0);
   assign rd_data  = mem[rd_ptr];

   always_comb
   begin
      next_count = count;
      if (push && !pop)
         next_count = count + 1'b1;
      else if (pop && !push)
         next_count = count - 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (push)
         mem[wr_ptr] <= wr_data;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         wr_ptr   <= '0;
         rd_ptr   <= '0;
         count    <= '0;
         wr_ready <= 1'b0;
      end
      else
      begin
         if (push)
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         count    <= next_count;
         // Registered ready looks one count ahead
         wr_ready <= (next_count != (AW + 1)'(DEPTH));
      end
   end
endmodule

// ----------------------------------------------------------------------
// Frame generator
// ----------------------------------------------------------------------
module pfg_frame_gen
#(
   parameter int FIFO_DEPTH = pfg_pkg::FIFO_DEPTH
)
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Packet bytes from multiplexer
   input  wire logic [7:0] in_data,
   input  wire logic       in_valid,
   output logic            in_ready,
   // Frame bytes out
   output logic      [7:0] out_data,
   output logic            out_valid,
   input  wire logic       out_ready,
   output logic            out_fec
);
   localparam logic [135:0] GEN = pfg_pkg::gen_poly();

   pfg_pkg::pfg_state_t state;
   logic [7:0]   f_data;
   logic         f_valid;
   logic         f_ready;
   logic         adv;
   logic         take;
   logic         fec_step;
   logic         last_in;
   logic         last_fec;
   logic [3:0]   row;
   logic [7:0]   col;
   logic [127:0] par [pfg_pkg::ROWS];
   logic [7:0]   fb;
   logic [127:0] fb_vec;
   logic [127:0] next_par;
   logic [3:0]   pkt;
   logic [4:0]   fbyte;
   logic [3:0]   prow;
   logic [4:0]   pcol;
   logic [6:0]   pbit;
   logic [7:0]   fec_byte;

   // ------------------------------------------------------------------
   // Input buffer
   // ------------------------------------------------------------------
   pfg_fifo
   #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   )
   u_fifo
   (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .wr_data  (in_data),
      .wr_valid (in_valid),
      .wr_ready (in_ready),
      .rd_data  (f_data),
      .rd_valid (f_valid),
      .rd_ready (f_ready)
   );

   // ------------------------------------------------------------------
   // Flow control
   // ------------------------------------------------------------------
   // Output register is free when empty or being taken
   assign adv      = !out_valid || out_ready;
   assign f_ready  = (state == pfg_pkg::PFG_DATA) && adv;
   assign take     = f_ready && f_valid;
   assign fec_step = (state == pfg_pkg::PFG_FEC) && adv;
   assign last_in  = (row == 4'(pfg_pkg::ROWS - 1)) &&
                     (col == 8'(pfg_pkg::DATA_COLS - 1));
   assign last_fec = (pkt == 4'(pfg_pkg::FEC_PKTS - 1)) &&
                     (fbyte == 5'(pfg_pkg::FEC_PKT_LEN - 1));

   // ------------------------------------------------------------------
   // Set sequencing
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         state <= pfg_pkg::PFG_DATA;
      else
      begin
         case (state)
            pfg_pkg::PFG_DATA:
            begin
               if (take && last_in)
                  state <= pfg_pkg::PFG_FEC;
            end
            pfg_pkg::PFG_FEC:
            begin
               if (fec_step && last_fec)
                  // First byte of the next set follows the last pad byte
                  state <= pfg_pkg::PFG_DATA;
            end
            default:
               state <= pfg_pkg::PFG_DATA;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Table position
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         row <= 4'h0;
         col <= 8'h00;
      end
      else if (take)
      begin
         if (row == 4'(pfg_pkg::ROWS - 1))
         begin
            row <= 4'h0;
            col <= last_in ? 8'h00 : col + 8'h01;
         end
         else
            row <= row + 4'h1;
      end
   end

   // ------------------------------------------------------------------
   // Row parity accumulation
   // ------------------------------------------------------------------
   // Encoder state starts at zero; leading shortening zeros keep it there
   assign fb = f_data ^ par[row][127:120];

   genvar gi;
   generate
      for (gi = 0; gi < pfg_pkg::PAR_COLS; gi++)
      begin : g_tap
         assign fb_vec[8*gi +: 8] = pfg_pkg::gf_mul(fb, GEN[8*gi +: 8]);
      end
   endgenerate

   assign next_par = {par[row][119:0], 8'h00} ^ fb_vec;

   always_ff @(posedge clk_sys)
   begin
      // Cleared as the last pad byte loads, ready for the next set
      if (rst || (fec_step && last_fec))
      begin
         for (int r = 0; r < pfg_pkg::ROWS; r++)
            par[r] <= '0;
      end
      else if (take)
         par[row] <= next_par;
   end

   // ------------------------------------------------------------------
   // FEC packet position
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pkt   <= 4'h0;
         fbyte <= 5'h00;
         prow  <= 4'h0;
         pcol  <= 5'h00;
      end
      else if (fec_step)
      begin
         if (fbyte == 5'(pfg_pkg::FEC_PKT_LEN - 1))
         begin
            fbyte <= 5'h00;
            pkt   <= last_fec ? 4'h0 : pkt + 4'h1;
         end
         else
            fbyte <= fbyte + 5'h01;
         if (last_fec)
         begin
            prow <= 4'h0;
            pcol <= 5'h00;
         end
         // Pointer parks at column 16 once all parity is out
         else if (fbyte >= 5'(pfg_pkg::FEC_HDR_LEN) && pcol != 5'(pfg_pkg::PAR_COLS))
         begin
            if (prow == 4'(pfg_pkg::ROWS - 1))
            begin
               prow <= 4'h0;
               pcol <= pcol + 5'h01;
            end
            else
               prow <= prow + 4'h1;
         end
      end
   end

   // ------------------------------------------------------------------
   // FEC byte selection
   // ------------------------------------------------------------------
   // Parity column 1 is the highest encoder stage
   assign pbit = 7'd120 - {pcol[3:0], 3'b000};

   always_comb
   begin
      if (fbyte == 5'h00)
         fec_byte = {pfg_pkg::FEC_LEN_CODE, pkt, pfg_pkg::FEC_ADDR[9:8]};
      else if (fbyte == 5'h01)
         fec_byte = pfg_pkg::FEC_ADDR[7:0];
      else if (pcol == 5'(pfg_pkg::PAR_COLS))
         fec_byte = 8'h00;
      else
         fec_byte = par[prow][pbit +: 8];
   end

   // ------------------------------------------------------------------
   // Output register
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         out_data  <= 8'h00;
         out_valid <= 1'b0;
         out_fec   <= 1'b0;
      end
      else if (take)
      begin
         out_data  <= f_data;
         out_valid <= 1'b1;
         out_fec   <= 1'b0;
      end
      else if (fec_step)
      begin
         out_data  <= fec_byte;
         out_valid <= 1'b1;
         out_fec   <= 1'b1;
      end
      else if (adv)
         out_valid <= 1'b0;
   end
endmodule

// ### tb/pfg_frame_gen_properties.sv
// Port checker for the packet FEC frame generator.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module pfg_frame_gen_properties
#(
   parameter int FIFO_DEPTH = 16
)
(
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       rst,
   // Input stream
   input wire logic [7:0] in_data,
   input wire logic       in_valid,
   input wire logic       in_ready,
   // Output stream
   input wire logic [7:0] out_data,
   input wire logic       out_valid,
   input wire logic       out_ready,
   input wire logic       out_fec
);
   logic [11:0] dcnt;
   logic [4:0]  pos;
   logic [3:0]  pk;
   logic        take;
   logic        last;
   assign take = out_valid && out_ready;
   assign last = take && out_fec && pk == 4'h8 && pos == 5'h17;
   // Data bytes taken in the current set
   always_ff @(posedge clk_sys)
   begin
      if (rst || last)
         dcnt <= 12'h000;
      else if (take && !out_fec)
         dcnt <= dcnt + 12'h001;
   end
   // Byte and packet position within the FEC packets
   always_ff @(posedge clk_sys)
   begin
      if (rst || last)
      begin
         pos <= 5'h00;
         pk  <= 4'h0;
      end
      else if (take && out_fec)
      begin
         pos <= (pos == 5'h17) ? 5'h00 : pos + 5'h01;
         pk  <= (pos == 5'h17) ? pk + 4'h1 : pk;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_reset_quiet: assert property (
      $past(rst) |-> !out_valid && !in_ready && out_data == 8'h00)
      else $error("outputs not cleared by reset");
   a_ready_after_reset: assert property ($past(rst) |=> in_ready)
      else $error("input not ready after reset");
   a_hold_on_stall: assert property (
      out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_fec))
      else $error("output changed while stalled");
   a_fec_phase: assert property (out_valid |-> out_fec == (dcnt == 12'h8d0))
      else $error("FEC flag does not match set position");
   a_fec_head_len: assert property (
      out_valid && out_fec && pos == 5'h00 |-> out_data == {2'b00, pk, 2'b11})
      else $error("FEC header byte 0 wrong");
   a_fec_head_addr: assert property (
      out_valid && out_fec && pos == 5'h01 |-> out_data == 8'hfe)
      else $error("FEC header byte 1 wrong");
   a_fec_pad_zero: assert property (
      out_valid && out_fec && pk == 4'h8 && pos >= 5'h12 |-> out_data == 8'h00)
      else $error("FEC padding not zero");
   a_set_restarts: assert property (last |=> !out_valid || !out_fec)
      else $error("FEC continues past ninth packet");
endmodule

bind pfg_frame_gen pfg_frame_gen_properties #(.FIFO_DEPTH(FIFO_DEPTH))
   pfg_frame_gen_properties_inst (
   .clk_sys(clk_sys), .rst(rst), .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
   .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready), .out_fec(out_fec));

// ### tb/pfg_sink.sv
// Downstream receive side: accepts frame bytes, optionally stalling.
// Assumes the bench owns the seed of the random stream.
`timescale 1ns/1ps
module pfg_sink
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Control and handshake
   input wire logic stall_en,
   output logic     out_ready
);
   initial
      out_ready = 1'b0;
   always @(posedge clk_sys)
      #1 out_ready = !rst && (!stall_en || $urandom_range(1) == 1);
endmodule

// ### tb/tb_top.sv
// Bench for the packet FEC frame generator: random sets, own encoder model.
// Assumes the downstream sink model and the bound port checker.
`timescale 1ns/1ps
module tb_top;
   logic       clk_sys;
   logic       rst;
   logic [7:0] in_data;
   logic       in_valid;
   logic       in_ready;
   logic [7:0] out_data;
   logic       out_valid;
   logic       out_ready;
   logic       out_fec;
   logic       stall_en;
   logic [7:0] dat [2256];
   logic [7:0] par [192];
   logic [7:0] gc [17];
   logic [8:0] expq [$];
   logic [7:0] rx [2472];
   int         rxn = 0;
   int         miscompares = 0;
   int         checks_done = 0;

   pfg_frame_gen pfg_frame_gen_inst (.clk_sys(clk_sys), .rst(rst), .in_data(in_data),
      .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data), .out_valid(out_valid),
      .out_ready(out_ready), .out_fec(out_fec));
   pfg_sink pfg_sink_inst (.clk_sys(clk_sys), .rst(rst), .stall_en(stall_en),
      .out_ready(out_ready));

   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   function automatic logic [7:0] gm(logic [7:0] a, logic [7:0] b);
      logic [7:0] p;
      p = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         if (b[i])
            p = p ^ a;
         a = a[7] ? ({a[6:0], 1'b0} ^ 8'h1d) : {a[6:0], 1'b0};
      end
      return p;
   endfunction

   // Header, parity down rows then columns, zero tail
   function automatic logic [7:0] fec_byte(int i);
      int k;
      int j;
      k = i / 24;
      j = i % 24 - 2;
      if (j < 0)
         return (j == -2) ? {2'b00, 4'(k), 2'b11} : 8'hfe;
      return (k * 22 + j < 192) ? par[k * 22 + j] : 8'h00;
   endfunction

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check_byte(input logic [8:0] exp, input logic [8:0] got);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH out_stream exp %h got %h", exp, got);
      end
   endtask

   task automatic check_syndrome(input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH row_syndrome exp %h got %h", exp, got);
      end
   endtask

   // Receive side: each received row must vanish at all sixteen roots
   task automatic check_rows();
      logic [7:0] s;
      logic [7:0] x;
      logic [7:0] b;
      int         p;
      for (int m = 0; m < 12; m++)
      begin
         x = 8'h01;
         for (int i = 0; i < 16; i++)
         begin
            s = 8'h00;
            for (int c = 0; c < 204; c++)
            begin
               p = c * 12 + m - 2256;
               if (c < 188)
                  b = rx[c * 12 + m];
               else
                  b = rx[2258 + p / 22 * 24 + p % 22];
               s = gm(s, x) ^ b;
            end
            check_syndrome(8'h00, s);
            x = gm(x, 8'h02);
         end
      end
   endtask

   // Packets of 24 to 96 bytes fill the set; RS parity per row
   task automatic build_set(input int kind);
      logic [7:0] r [16];
      logic [7:0] fb;
      int         len;
      for (int n = 0; n < 2256; n += len)
      begin
         len = (kind == 0) ? 96 : 24 * (1 + $urandom_range(3));
         if (len > 2256 - n)
            len = 2256 - n;
         for (int i = n; i < n + len; i++)
            dat[i] = (kind == 0) ? 8'hff : 8'($urandom);
         dat[n][7:6] = 2'(len / 24 - 1);
      end
      for (int i = 0; i < 2256; i++)
         expq.push_back({1'b0, dat[i]});
      for (int m = 0; m < 12; m++)
      begin
         r = '{default: 8'h00};
         for (int c = 0; c < 188; c++)
         begin
            fb = dat[c * 12 + m] ^ r[15];
            for (int j = 15; j > 0; j--)
               r[j] = r[j - 1] ^ gm(fb, gc[j]);
            r[0] = gm(fb, gc[0]);
         end
         for (int k = 0; k < 16; k++)
            par[k * 12 + m] = r[15 - k];
      end
      for (int i = 0; i < 216; i++)
         expq.push_back({1'b1, fec_byte(i)});
   endtask

   task automatic send_set(input int kind, input int stop);
      logic rdy;
      build_set(kind);
      for (int i = 0; i < stop; i++)
      begin
         in_data = dat[i];
         in_valid = 1'b1;
         rdy = 1'b0;
         for (int w = 0; w < 2000 && !rdy; w++)
         begin
            @(negedge clk_sys);
            rdy = in_ready;
            @(posedge clk_sys);
            #1;
         end
         if (!rdy)
         begin
            miscompares++;
            end_of_test();
         end
         if (kind == 1 && $urandom_range(3) == 0)
         begin
            in_valid = 1'b0;
            @(posedge clk_sys);
            #1;
         end
      end
      in_valid = 1'b0;
      @(posedge clk_sys);
      #1;
   endtask

   // Every byte taken downstream against the expected frame stream
   always @(negedge clk_sys)
   begin
      logic [8:0] got;
      got = {out_fec, out_data};
      if (rst)
         rxn = 0;
      else if (out_valid === 1'b1 && out_ready === 1'b1)
      begin
         if (expq.size() == 0)
            check_byte(9'h1ff, got);
         else if (rxn < 2256)
            check_byte(expq.pop_front(), got);
         else if ((rxn - 2256) % 24 < 2)
            check_byte(expq.pop_front(), got);
         else
            check_byte(expq.pop_front(), got);
         rx[rxn] = got[7:0];
         rxn++;
         if (rxn == 2472)
         begin
            check_rows();
            rxn = 0;
         end
      end
   end

   initial
   begin
      logic [7:0] a;
      rst = 1'b1;
      in_valid = 1'b0;
      in_data = 8'h00;
      stall_en = 1'b0;
      void'($urandom(32'ha7e1ac41));
      gc = '{default: 8'h00};
      gc[0] = 8'h01;
      a = 8'h01;
      for (int i = 0; i < 16; i++)
      begin
         for (int j = 16; j > 0; j--)
            gc[j] = gc[j - 1] ^ gm(a, gc[j]);
         gc[0] = gm(a, gc[0]);
         a = gm(a, 8'h02);
      end
      repeat (20) @(posedge clk_sys);
      #1 rst = 1'b0;
      send_set(0, 2256);
      stall_en = 1'b1;
      send_set(1, 2256);
      stall_en = 1'b0;
      // Reset in mid-set; the next set must start at row 1, column 1
      send_set(2, 900);
      rst = 1'b1;
      expq.delete();
      repeat (3) @(posedge clk_sys);
      #1 rst = 1'b0;
      send_set(2, 2256);
      for (int w = 0; w < 3000 && expq.size() > 0; w++)
         @(posedge clk_sys);
      if (expq.size() > 0)
         miscompares++;
      end_of_test();
   end
endmodule
